// ===== rtl/disk_cmd_regs.vh
// Purpose: constants of the disk command acceptance block
// Assumes: pclk at 10 MHz
// Notes: byte offsets on the APB register window
`ifndef DISK_CMD_REGS_VH
`define DISK_CMD_REGS_VH
`define OFF_DATA 12'h000
`define OFF_FEATURES 12'h004
`define OFF_SECTOR_COUNT 12'h008
`define OFF_SECTOR_NUMBER 12'h00c
`define OFF_CYL_LOW 12'h010
`define OFF_CYL_HIGH 12'h014
`define OFF_DEVICE_HEAD 12'h018
`define OFF_COMMAND 12'h01c
`define OFF_CONTROL 12'h020
`define OFF_EVENT 12'h024
`define OFF_INFO 12'h028
// control register fields
`define CTL_STANDBY 0
`define CTL_SECONDARY 1
`define CTL_HAS_SECONDARY 2
`define CTL_SELF_CODE_LSB 4
// event register bits (write 1)
`define EVT_BUF_SET 0
`define EVT_BUF_FILLED 1
`define EVT_WORK_DONE 2
`define EVT_WORK_ERR 3
// status, error and device head bits
`define ST_BUSY 7
`define ST_DRDY 6
`define ST_DRQ 3
`define ST_ERR 0
`define ERR_ABORT 2
`define DEVSEL_BIT 4
`define LBA_BIT 6
// reset values and result codes
`define RST_DH 8'ha0
`define RST_ERROR 8'h01
`define RST_SC 8'h01
`define DIAG_SEC_FAIL 8'h80
`define PM_STANDBY 8'h00
`define PM_IDLE 8'hff
// timing
`define CLK_HZ 10000000
`define T_BUSY_NS 400
`define T_DRQ2_US 700
`define T_DRQ3_MS 20
`define T_SEC_PASS_S 5
`define T_PRI_WAIT_S 6
`endif

// ===== rtl/disk_command_acceptance.v
// Purpose: command acceptance and dispatch of a disk host interface
// Assumes: apb inputs synchronous to pclk; firmware answers events
// Notes: the sector buffer and media work are outside; their progress
//   arrives through the event register, the block keeps the flags
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "disk_cmd_regs.vh"

// Behaviour
// - commands accepted only while busy is clear
// - first class raises busy within 400 ns
// - second class: drq within 700 us
// - third class: drq within 20 ms
// - new command abandons the unfinished one
// - opcodes sorted into three acceptance classes
// - full opcode set decoded, aliases included
// - every parameter field written while not busy is captured
// - diagnostic ignores the device select bit
// - power query in standby writes 00h
// - power query in idle writes ffh
// - secondary asserts passed diag within 5 s
// - primary waits 6 s, ors 80h
// - no secondary: own result, then interrupt
// - error holds diagnostic code after diagnostics
// - flush keeps busy until done or error
// - format raises drq, waits buffer, then busy
// - format zeros data fields, not id
// - lba format acts on one logical track
// - busy reads of registers 0x04 to 0x1c return status
// - status read clears pending interrupt
// - invalid or refused opcodes set abort
module disk_command_acceptance #(
  parameter CLK_HZ = `CLK_HZ,
  parameter DRQ3_CYCLES = (`CLK_HZ / 1000) * `T_DRQ3_MS,
  parameter SEC_PASS_CYCLES = `CLK_HZ * `T_SEC_PASS_S,
  parameter PRI_WAIT_CYCLES = `CLK_HZ * `T_PRI_WAIT_S,
  parameter DRQ2_CYCLES = (`CLK_HZ / 1000000) * `T_DRQ2_US
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire passed_diag_n_in,
  output reg passed_diag_n_out,
  output reg passed_diag_n_oe,
  output reg intrq,
  output reg busy_flag,
  output reg data_request_flag,
  output reg zero_fill,
  output reg [27:0] work_addr
);

  // ------------------------------------------------------------
  // register window, one byte lane per word
  // ------------------------------------------------------------
  // 0x00 data port, handled outside this block
  // 0x04 features on write, error code on read
  // 0x08 sector count, 0x0c sector number
  // 0x10 and 0x14 cylinder low and high bytes
  // 0x18 device and head, 0x1c command and status
  // 0x20 control: standby, secondary role, secondary present, own code
  // 0x24 event strobes from firmware, write one to signal
  // 0x28 state and latched opcode, for inspection only
  // the error word reads back whatever the last command left behind;
  // after diagnostics it is a code, not a set of flags

  // ------------------------------------------------------------
  // timing and state encoding
  // ------------------------------------------------------------
  // busy must rise within 400 ns; latency here is one cycle
  localparam [31:0] BUSY_CYCLES = (`T_BUSY_NS * (CLK_HZ / 1000000)) / 1000;

  localparam [6:0] S_IDLE = 7'b0000001;
  localparam [6:0] S_EXEC = 7'b0000010;
  localparam [6:0] S_PREP = 7'b0000100;
  localparam [6:0] S_XFER = 7'b0001000;
  localparam [6:0] S_FMT_WAIT = 7'b0010000;
  localparam [6:0] S_DIAG = 7'b0100000;
  localparam [6:0] S_DONE = 7'b1000000;

  localparam [1:0] CL_ONE = 2'd1;
  localparam [1:0] CL_TWO = 2'd2;
  localparam [1:0] CL_THREE = 2'd3;

  // ------------------------------------------------------------
  // state held by the block
  // ------------------------------------------------------------
  reg [6:0] state;
  reg [7:0] features_param;
  reg [7:0] sector_count_param;
  reg [7:0] sector_number_param;
  reg [15:0] cylinder_param;
  reg [7:0] device_head_param;
  reg [7:0] error_reg;
  reg [7:0] opcode;
  reg [7:0] control;
  reg err_bit;
  reg drdy;
  reg [31:0] timer;
  reg [31:0] sec_timer;
  reg sec_running;
  reg [1:0] cls;
  reg valid_op;
  reg diag_op;

  // ------------------------------------------------------------
  // bus decode and status view
  // ------------------------------------------------------------
  wire [7:0] cmd_code = pwdata[7:0];
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire [7:0] status = {busy_flag, drdy, 1'b0, 1'b1, data_request_flag, 2'b00, err_bit};
  // diagnostics go to both drives whatever the select bit says
  wire is_diag = (cmd_code == 8'h90);
  wire addressed = is_diag || !device_head_param[`DEVSEL_BIT] ^ control[`CTL_SECONDARY];
  wire evt = wr && (paddr == `OFF_EVENT);

  // ------------------------------------------------------------
  // opcode classification
  // ------------------------------------------------------------
  always @* begin
    valid_op = 1'b1;
    cls = CL_ONE;
    casez (cmd_code)
      8'h92, 8'h50, 8'he8, 8'h30, 8'h31, 8'h32, 8'h33: cls = CL_TWO;
      8'hca, 8'hcb, 8'hc5: cls = CL_THREE;
      8'h98, 8'he5, 8'h90, 8'he7, 8'hec, 8'h97, 8'he3, 8'h95, 8'he1, 8'h91,
      8'he4, 8'hc8, 8'hc9, 8'h22, 8'h23, 8'hc4, 8'hf8, 8'h20, 8'h21, 8'h40,
      8'h41, 8'h1?, 8'h7?, 8'hef, 8'hf9, 8'hc6, 8'h99, 8'he6, 8'hb0, 8'h96,
      8'he2, 8'h94, 8'he0: cls = CL_ONE;
      // unknown codes fall to the default arm and end in abort
      default: valid_op = 1'b0;
    endcase
  end

  always @* begin
    diag_op = (opcode == 8'h90);
  end

  // ------------------------------------------------------------
  // apb slave, zero wait states
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // answered from a registered copy, so pready lags setup by one edge
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        if (busy_flag && paddr <= `OFF_COMMAND && paddr != `OFF_DATA) begin
          prdata <= {24'h000000, status};
        end else if (paddr == `OFF_FEATURES) begin
          prdata <= {24'h000000, error_reg};
        end else if (paddr == `OFF_SECTOR_COUNT) begin
          prdata <= {24'h000000, sector_count_param};
        end else if (paddr == `OFF_SECTOR_NUMBER) begin
          prdata <= {24'h000000, sector_number_param};
        end else if (paddr == `OFF_CYL_LOW) begin
          prdata <= {24'h000000, cylinder_param[7:0]};
        end else if (paddr == `OFF_CYL_HIGH) begin
          prdata <= {24'h000000, cylinder_param[15:8]};
        end else if (paddr == `OFF_DEVICE_HEAD) begin
          prdata <= {24'h000000, device_head_param};
        end else if (paddr == `OFF_COMMAND) begin
          prdata <= {24'h000000, status};
        end else if (paddr == `OFF_CONTROL) begin
          prdata <= {24'h000000, control};
        end else if (paddr == `OFF_INFO) begin
          prdata <= {16'h0000, {1'b0, state}, opcode};
        end else if (paddr != `OFF_DATA && paddr != `OFF_EVENT) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // parameter registers and command engine
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      features_param <= 8'h00;
      sector_count_param <= `RST_SC;
      sector_number_param <= 8'h01;
      cylinder_param <= 16'h0000;
      device_head_param <= `RST_DH;
      error_reg <= `RST_ERROR;
      opcode <= 8'h00;
      control <= 8'h00;
      err_bit <= 1'b0;
      drdy <= 1'b1;
      timer <= 32'h00000000;
      intrq <= 1'b0;
      busy_flag <= 1'b0;
      data_request_flag <= 1'b0;
      zero_fill <= 1'b0;
      work_addr <= 28'h0000000;
    end else begin
      if (rd && paddr == `OFF_COMMAND) begin
        intrq <= 1'b0;
      end
      if (wr && paddr == `OFF_CONTROL) begin
        control <= pwdata[7:0];
      end
      // the host keeps off the parameters while busy
      if (wr && !busy_flag) begin
        if (paddr == `OFF_FEATURES) begin
          features_param <= pwdata[7:0];
        end else if (paddr == `OFF_SECTOR_COUNT) begin
          sector_count_param <= pwdata[7:0];
        end else if (paddr == `OFF_SECTOR_NUMBER) begin
          sector_number_param <= pwdata[7:0];
        end else if (paddr == `OFF_CYL_LOW) begin
          cylinder_param[7:0] <= pwdata[7:0];
        end else if (paddr == `OFF_CYL_HIGH) begin
          cylinder_param[15:8] <= pwdata[7:0];
        end else if (paddr == `OFF_DEVICE_HEAD) begin
          device_head_param <= pwdata[7:0];
        end
      end
      // one shared down counter serves the drq and primary wait deadlines
      if (timer != 32'h00000000) begin
        timer <= timer - 32'h00000001;
      end
      if (wr && paddr == `OFF_COMMAND && !busy_flag && addressed) begin
        // a new code drops whatever ran before, even drq phases
        opcode <= cmd_code;
        data_request_flag <= 1'b0;
        zero_fill <= 1'b0;
        err_bit <= 1'b0;
        intrq <= 1'b0;
        // only used fields form the work address: lba or chs
        work_addr <= {device_head_param[3:0], cylinder_param, sector_number_param};
        // refused codes still end the old command, with abort
        if (!valid_op) begin
          error_reg <= 8'h01 << `ERR_ABORT;
          err_bit <= 1'b1;
          intrq <= 1'b1;
          state <= S_IDLE;
        end else if (is_diag) begin
          busy_flag <= 1'b1;
          timer <= PRI_WAIT_CYCLES;
          state <= S_DIAG;
        end else if (cls == CL_ONE) begin
          busy_flag <= 1'b1;
          state <= S_EXEC;
          // power query finishes in one pass: no firmware event is needed
          if (cmd_code == 8'h98 || cmd_code == 8'he5) begin
            sector_count_param <= control[`CTL_STANDBY] ? `PM_STANDBY : `PM_IDLE;
            state <= S_DONE;
          end
        end else begin
          busy_flag <= 1'b1;
          timer <= (cls == CL_TWO) ? DRQ2_CYCLES : DRQ3_CYCLES;
          state <= S_PREP;
        end
      end else begin
        case (state)
          S_IDLE: begin
          end
          S_EXEC: begin
            // flush and the rest stay busy until firmware reports
            if (evt && pwdata[`EVT_WORK_DONE]) begin
              state <= S_DONE;
            end else if (evt && pwdata[`EVT_WORK_ERR]) begin
              error_reg <= 8'h01 << `ERR_ABORT;
              err_bit <= 1'b1;
              state <= S_DONE;
            end
          end
          S_PREP: begin
            // drq forced at the deadline if the buffer is slow
            if ((evt && pwdata[`EVT_BUF_SET]) || timer == 32'h00000000) begin
              data_request_flag <= 1'b1;
              busy_flag <= 1'b0;
              state <= (opcode == 8'h50) ? S_FMT_WAIT : S_XFER;
            end
          end
          S_XFER: begin
            // host is moving sector data; firmware says when the buffer is full
            if (evt && pwdata[`EVT_BUF_FILLED]) begin
              data_request_flag <= 1'b0;
              busy_flag <= 1'b1;
              state <= S_EXEC;
            end
          end
          S_FMT_WAIT: begin
            if (evt && pwdata[`EVT_BUF_FILLED]) begin
              data_request_flag <= 1'b0;
              busy_flag <= 1'b1;
              // data fields only; ids stay as they are
              zero_fill <= 1'b1;
              if (device_head_param[`LBA_BIT]) begin
                // one logical track: the one holding the given block
                work_addr <= {device_head_param[3:0], cylinder_param, 8'h00};
              end else begin
                work_addr <= {device_head_param[3:0], cylinder_param, 8'h01};
              end
              state <= S_EXEC;
            end
          end
          S_DIAG: begin
            // secondary role or lone drive: report own code at once
            // as primary, a low line means the peer passed; silence
            // until the deadline marks the peer as failed
            if (control[`CTL_SECONDARY] || !control[`CTL_HAS_SECONDARY]) begin
              error_reg <= {4'h0, control[7:4]};
              state <= S_DONE;
            end else if (!passed_diag_n_in) begin
              error_reg <= {4'h0, control[7:4]};
              state <= S_DONE;
            end else if (timer == 32'h00000000) begin
              error_reg <= `DIAG_SEC_FAIL | {4'h0, control[7:4]};
              state <= S_DONE;
            end
          end
          S_DONE: begin
            // busy falls and the interrupt rises on the same edge
            busy_flag <= 1'b0;
            zero_fill <= 1'b0;
            intrq <= 1'b1;
            state <= S_IDLE;
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // secondary side of the passed diagnostics line
  // ------------------------------------------------------------
  // the line is open drain: enable high pulls it low to say passed
  // a failed self test never drives, so the primary times out

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_timer <= 32'h00000000;
      sec_running <= 1'b0;
      passed_diag_n_out <= 1'b0;
      passed_diag_n_oe <= 1'b0;
    end else begin
      passed_diag_n_out <= 1'b0;
      if (wr && paddr == `OFF_COMMAND && is_diag && control[`CTL_SECONDARY]) begin
        sec_running <= 1'b1;
        sec_timer <= 32'h00000000;
        passed_diag_n_oe <= 1'b0;
      end else if (sec_running) begin
        sec_timer <= sec_timer + 32'h00000001;
        // asserted once own result passes, well before the 5 s bound
        if (control[7:4] == 4'h1 && sec_timer < SEC_PASS_CYCLES) begin
          passed_diag_n_oe <= 1'b1;
          sec_running <= 1'b0;
        end else if (sec_timer >= SEC_PASS_CYCLES) begin
          sec_running <= 1'b0;
        end
      end
    end
  end

endmodule

// ===== bench/disk_command_acceptance_assertions.sv
// Purpose: temporal checks on the command acceptance block ports
// Assumes: one clock domain, zero wait-state apb slave
// Notes: opcode-specific checks use codes the bench really issues
`timescale 1ns/100ps
module disk_cmd_checker #(
  parameter DRQ3_CYCLES = 30
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire intrq,
  input wire busy_flag,
  input wire data_request_flag,
  input wire zero_fill
);
  // small margin lets the timer land on either side of the decode edge
  localparam int drq3_lim = DRQ3_CYCLES + 4;
  wire wr_acc = psel && penable && pwrite;
  wire cmd_wr = wr_acc && paddr == 12'h01c && !busy_flag;
  wire stat_rd = psel && penable && !pwrite && paddr == 12'h01c && pready;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_class1_busy: assert property (cmd_wr && pwdata[7:0] == 8'h90 |-> ##[1:4] busy_flag)
    else $error("busy late after diagnostic command");
  a_drq_drops_busy: assert property ($rose(data_request_flag) |-> ##[0:4] !busy_flag)
    else $error("busy held after data request");
  a_class3_drq: assert property (cmd_wr && pwdata[7:0] == 8'hca
    |-> ##[1:drq3_lim] data_request_flag)
    else $error("data request late on third class");
  a_new_cmd_wins: assert property (cmd_wr && data_request_flag && pwdata[7:0] == 8'hec
    |-> ##[1:4] (busy_flag && !data_request_flag))
    else $error("old command not abandoned");
  a_invalid_abort: assert property (cmd_wr && pwdata[7:0] == 8'h00
    |=> (!busy_flag throughout (##[0:3] intrq)))
    else $error("invalid opcode not ended with interrupt");
  a_fill_sets_busy: assert property (wr_acc && paddr == 12'h024 && pwdata[1] && data_request_flag
    |=> ##[0:3] (busy_flag && !data_request_flag))
    else $error("buffer fill did not start execution");
  a_zero_fill_busy: assert property (zero_fill |-> busy_flag)
    else $error("zero fill outside execution");
  a_status_clears: assert property (stat_rd && !busy_flag |=> !intrq)
    else $error("status read left interrupt pending");
  c_cmd: cover property (cmd_wr);
  c_drq: cover property ($rose(data_request_flag));
  c_fill: cover property ($rose(zero_fill));
endmodule

bind disk_command_acceptance disk_cmd_checker #(.DRQ3_CYCLES(DRQ3_CYCLES)) chk_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .intrq(intrq), .busy_flag(busy_flag),
  .data_request_flag(data_request_flag), .zero_fill(zero_fill));

// ===== bench/second_drive_model.sv
// Purpose: the other drive on the shared diagnostic line
// Assumes: line is open drain with a pull-up
// Notes: restarts its self test on every start pulse
`timescale 1ns/100ps
module second_drive_model #(
  parameter DELAY = 20
) (
  input wire pclk,
  input wire start,
  input wire pass,
  output reg drive_low
);
  int count = -1;
  initial drive_low = 1'b0;
  always @(posedge pclk) begin
    if (start) begin
      count <= DELAY;
      drive_low <= 1'b0;
    end else if (count == 0) begin
      drive_low <= pass;
      count <= -1;
    end else if (count > 0) begin
      count <= count - 1;
    end
  end
endmodule

// ===== bench/test_disk_command_acceptance.sv
// Purpose: self-checking bench for the command acceptance block
// Assumes: shortened timers, zero wait-state apb slave
// Notes: a partner model plays the second drive on the diag line
`timescale 1ns/100ps
module test_disk_command_acceptance;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg start = 1'b0;
  reg pass = 1'b0;
  reg [31:0] rd;
  reg slverr;
  wire [31:0] prdata;
  wire pready, pslverr, diag_oe, intrq, busy_flag, data_request_flag, zero_fill, drive_low;
  wire diag_line = !(diag_oe || drive_low);
  int err_total = 0;
  int num_checks = 0;
  int n;
  always #50 pclk = ~pclk;
  disk_command_acceptance #(.DRQ2_CYCLES(20), .DRQ3_CYCLES(30), .SEC_PASS_CYCLES(40),
    .PRI_WAIT_CYCLES(50)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .passed_diag_n_in(diag_line), .passed_diag_n_out(),
    .passed_diag_n_oe(diag_oe), .intrq(intrq), .busy_flag(busy_flag),
    .data_request_flag(data_request_flag), .zero_fill(zero_fill), .work_addr());
  second_drive_model #(.DELAY(20)) peer_u (.pclk(pclk), .start(start), .pass(pass),
    .drive_low(drive_low));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge pclk);
    end
    check("pready", pready, 1);
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // sel 0 waits interrupt, 1 data request, 2 diag drive; n counts edges
  task wait_on(input int sel, input int lim);
    n = 0;
    @(posedge pclk);
    while ((sel == 2 ? diag_oe : sel ? data_request_flag : intrq) !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task clear_irq;
    apb(0, 12'h01c, 0);
    @(posedge pclk);
    #1;
    check("intrq", intrq, 0);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_reset;
    apb(0, 12'h004, 0);
    check("error", rd[7:0], 8'h01);
    apb(0, 12'h030, 0);
    check("slverr", slverr, 1);
    $display("reset test done");
  endtask
  task t_power;
    for (int i = 0; i < 4; i++) begin
      apb(1, 12'h020, 32'(i % 2));
      apb(1, 12'h01c, i < 2 ? 32'h98 : 32'he5);
      wait_on(0, 20);
      apb(0, 12'h008, 0);
      check("sector count", rd[7:0], i % 2 ? 8'h00 : 8'hff);
      clear_irq;
    end
    $display("power test done");
  endtask
  task t_buffered;
    logic [7:0] ops [10] = '{8'h92, 8'h50, 8'he8, 8'h30, 8'h31, 8'h32, 8'h33,
      8'hca, 8'hcb, 8'hc5};
    for (int i = 0; i < 10; i++) begin
      apb(1, 12'h01c, {24'h0, ops[i]});
      @(posedge pclk);
      #1;
      check("busy", busy_flag, 1);
      wait_on(1, 40);
      check("drq", data_request_flag, 1);
      check("class", n > 24, i >= 7);
      repeat (4) @(posedge pclk);
      #1;
      check("busy drop", busy_flag, 0);
      apb(1, 12'h024, 2);
      @(posedge pclk);
      #1;
      check("exec busy", {busy_flag, data_request_flag}, 2'b10);
      check("zero fill", zero_fill, ops[i] == 8'h50);
      apb(1, 12'h024, 4);
      wait_on(0, 10);
      clear_irq;
    end
    $display("buffered test done");
  endtask
  task t_abandon;
    apb(1, 12'h01c, 32'h30);
    wait_on(1, 30);
    apb(1, 12'h01c, 32'hec);
    @(posedge pclk);
    #1;
    check("abandon", {busy_flag, data_request_flag}, 2'b10);
    apb(0, 12'h008, 0);
    check("busy read", rd[7], 1);
    apb(1, 12'h01c, 32'h00);
    repeat (4) @(posedge pclk);
    #1;
    check("ignored", intrq, 0);
    apb(1, 12'h024, 4);
    wait_on(0, 10);
    clear_irq;
    apb(1, 12'h01c, 32'h00);
    wait_on(0, 10);
    apb(0, 12'h004, 0);
    check("abort", rd[2], 1);
    clear_irq;
    $display("abandon test done");
  endtask
  task t_diag;
    for (int i = 0; i < 3; i++) begin
      apb(1, 12'h020, i < 2 ? 32'h14 : 32'h10);
      pass <= (i == 1);
      start <= 1'b1;
      apb(1, 12'h01c, 32'h90);
      start <= 1'b0;
      wait_on(0, 80);
      apb(0, 12'h004, 0);
      check("diag code", rd[7:0], i ? 8'h01 : 8'h81);
      if (i == 0) begin
        // peer failed: select it and read status for its own result
        apb(1, 12'h018, 32'hb0);
        apb(0, 12'h01c, 0);
        check("peer status", rd[7], 0);
        apb(1, 12'h018, 32'ha0);
      end
      clear_irq;
    end
    apb(1, 12'h020, 32'h12);
    apb(1, 12'h01c, 32'h90);
    wait_on(2, 45);
    check("pass line", diag_line, 0);
    $display("diag test done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_power;
    t_buffered;
    t_abandon;
    t_diag;
    finish_test;
  end
  // the whole run needs about 700 cycles
  initial begin
    #(8000 * 100);
    err_total++;
    finish_test;
  end
endmodule
